// ==== verilog/packet_handler.sv ====
/*
  Packet handler core: framing, filtering, checksum, balance coding and
  cipher sequencing between a host byte queue and a modem chip stream.
  Assumes the host keeps payload limits and refill/drain flow, and that
  rx chips arrive aligned to the programmed chip rate (no clock recovery).
*/
`timescale 1ns/1ps
`default_nettype none

`include "packet_handler_regs.svh"

// Function
// - rx cipher: store packet, decrypt, then complete
// - cipher on means queue is plain buffer
// - about 7 us per block before events
// - tx start-up delayed by encryption time
// - checksum on encrypted data, flag earlier
// - tx done only after final bit
// - drop packets without sync, no event
// - sync match starts reception, sets match flag
// - node filter own or own/group identifier
// - sync and address share match flag
// - length below limit accepted, byte kept
// - append and verify two-byte CCITT checksum
// - checksum fail clears or keeps queue
// - Manchester one as 10, zero 01
// - coding covers payload and checksum only
// - whitening with x9+x5+1 sequence
module packet_handler
  import packet_handler_pkg::*;
#(
  parameter int CIPHER_BLOCK_NS = `CIPHER_BLOCK_NS
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // operating mode
  input wire logic mode_tx_i,
  input wire logic mode_rx_i,
  // configuration
  input wire logic [15:0] chip_rate_setting_i,
  input wire logic [7:0] preamble_len_i,
  input wire logic [31:0] sync_pattern_i,
  input wire logic variable_length_i,
  input wire logic [7:0] length_limit_i,
  input wire logic [1:0] node_filter_select_i,
  input wire logic [7:0] own_node_id_i,
  input wire logic [7:0] group_node_id_i,
  input wire logic check_enable_i,
  input wire logic keep_on_check_fail_i,
  input wire logic [1:0] balance_coding_select_i,
  input wire logic cipher_enable_i,
  input wire logic [4:0] queue_threshold_i,
  // host byte path
  input wire logic host_wr_valid_i,
  input wire logic [7:0] host_wr_data_i,
  output logic host_wr_ready_o,
  output logic host_rd_valid_o,
  output logic [7:0] host_rd_data_o,
  input wire logic host_rd_ready_i,
  // modem chips
  input wire logic rx_chip_i,
  output logic tx_chip_o,
  // status flags
  output logic rx_message_available_o,
  output logic check_pass_flag_o,
  output logic tx_done_flag_o,
  output logic queue_level_flag_o,
  output logic queue_full_flag_o,
  output logic queue_nonempty_flag_o,
  output logic frame_match_flag_o
);

  localparam int CIPHER_CYCLES = CIPHER_BLOCK_NS / `MCLK_PERIOD_NS;

  core_state_t st;
  core_state_t nx;
  logic tick, bit_done, raw, rx_bit, finish_ok, fail_drop, discard;
  logic manch, white;
  logic [7:0] byte_val;
  logic [15:0] rx_crc;
  logic eng_push, eng_pop, q_clear, q_in_valid, q_out_ready, host_pop_ok;
  logic [7:0] q_in_data, q_out_data;
  logic q_in_ready, q_out_valid;
  logic [4:0] q_count;

  function automatic logic is_tx(input state_t s);
    is_tx = (s == ST_TX_CIPHER) || (s == ST_TX_PRE) || (s == ST_TX_SYNC) ||
            (s == ST_TX_DATA) || (s == ST_TX_CRC) || (s == ST_TX_DONE);
  endfunction : is_tx

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? `CRC_POLY : 16'h0000);
  endfunction : crc_step

  function automatic logic [8:0] lfsr_step(input logic [8:0] l);
    lfsr_step = {l[0] ^ l[`LFSR_TAP], l[8:1]};
  endfunction : lfsr_step

  function automatic logic [2:0] blocks_of(input logic [8:0] n);
    logic [9:0] t;
    t = {1'b0, n} + `CIPHER_BLOCK_ROUND;
    blocks_of = (t[9:4] > {3'h0, `CIPHER_MAX_BLOCKS}) ? `CIPHER_MAX_BLOCKS : t[6:4];
  endfunction : blocks_of

  ////////////////////////////////////////////////////////////////////////
  // byte queue

  // host may not read before decryption done
  assign host_pop_ok = !(cipher_enable_i && mode_rx_i && !st.rx_msg);
  assign q_in_valid = is_tx(st.state) || st.state == ST_IDLE ? host_wr_valid_i && !mode_rx_i : eng_push;
  assign q_in_data = eng_push ? byte_val : host_wr_data_i;
  assign q_out_ready = is_tx(st.state) ? eng_pop : host_rd_ready_i && host_pop_ok;

  byte_queue #(
    .WIDTH(`QUEUE_WIDTH),
    .DEPTH(`QUEUE_DEPTH)
  ) queue (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .clear_i(q_clear),
    .in_valid_i(q_in_valid),
    .in_data_i(q_in_data),
    .in_ready_o(q_in_ready),
    .out_valid_o(q_out_valid),
    .out_data_o(q_out_data),
    .out_ready_i(q_out_ready),
    .count_o(q_count)
  );

  ////////////////////////////////////////////////////////////////////////
  // engine

  assign manch = (balance_coding_select_i == `CODING_MANCH);
  assign white = (balance_coding_select_i == `CODING_WHITE);
  assign tick = (st.tick_cnt == 16'h0000);

  always_comb begin
    nx = st;
    eng_push = 1'b0;
    eng_pop = 1'b0;
    q_clear = 1'b0;
    bit_done = 1'b0;
    raw = 1'b0;
    rx_bit = 1'b0;
    finish_ok = 1'b0;
    fail_drop = 1'b0;
    discard = 1'b0;
    byte_val = 8'h00;
    rx_crc = 16'h0000;
    // rx pin filter: a change counts once stages two and three agree
    nx.rx_pipe = {st.rx_pipe[1:0], rx_chip_i};
    if (st.rx_pipe[1] == st.rx_pipe[2]) begin
      nx.rx_level = st.rx_pipe[2];
    end
    if (tick) begin
      nx.tick_cnt = (chip_rate_setting_i == 16'h0000) ? 16'h0000 : chip_rate_setting_i - 1'b1;
    end else begin
      nx.tick_cnt = st.tick_cnt - 1'b1;
    end
    nx.level = (q_count > queue_threshold_i);
    nx.full = (q_count == 5'(`QUEUE_DEPTH));
    nx.nonempty = (q_count != 5'h00);
    if (!mode_tx_i) begin
      nx.tx_done = 1'b0;
    end
    case (st.state)
      ST_IDLE: begin
        nx.chip = 1'b0;
        nx.pre_cnt = preamble_len_i;
        nx.bit_cnt = `BYTE_TOP;
        if (mode_tx_i && q_out_valid) begin
          if (cipher_enable_i) begin
            nx.blocks_left = blocks_of({4'h0, q_count});
            nx.cipher_cnt = 16'(CIPHER_CYCLES - 1);
            nx.state = ST_TX_CIPHER;
          end else begin
            nx.state = ST_TX_PRE;
          end
        end else if (mode_rx_i) begin
          nx.state = ST_RX_HUNT;
          nx.sync_sh = 32'h0000_0000;
          nx.frame_match = 1'b0;
          nx.rx_msg = 1'b0;
          nx.check_pass = 1'b0;
        end
      end
      ST_TX_CIPHER, ST_RX_CIPHER: begin
        if (st.cipher_cnt != 16'h0000) begin
          nx.cipher_cnt = st.cipher_cnt - 1'b1;
        end else if (st.blocks_left > 3'h1) begin
          nx.blocks_left = st.blocks_left - 1'b1;
          nx.cipher_cnt = 16'(CIPHER_CYCLES - 1);
        end else if (st.state == ST_TX_CIPHER) begin
          nx.state = ST_TX_PRE;
        end else begin
          nx.rx_msg = 1'b1;
          nx.state = ST_RX_END;
        end
      end
      ST_TX_PRE: begin
        if (tick) begin
          if (st.pre_cnt == 8'h00) begin
            nx.chip = sync_pattern_i[`SYNC_TOP];
            nx.sidx = `SYNC_TOP - 1'b1;
            nx.state = ST_TX_SYNC;
          end else begin
            nx.chip = ~st.chip;
            nx.bit_cnt = st.bit_cnt - 1'b1;
            if (st.bit_cnt == 3'h0) begin
              nx.pre_cnt = st.pre_cnt - 1'b1;
            end
          end
        end
      end
      ST_TX_SYNC: begin
        if (tick) begin
          nx.chip = sync_pattern_i[st.sidx];
          nx.sidx = st.sidx - 1'b1;
          if (st.sidx == 5'h00) begin
            // address byte is plain host payload
            eng_pop = 1'b1;
            nx.shreg = q_out_data;
            nx.pay_len = variable_length_i ? {1'b0, q_out_data} + 1'b1 : {1'b0, length_limit_i};
            nx.byte_cnt = 8'h00;
            nx.bit_cnt = `BYTE_TOP;
            nx.half = 1'b0;
            nx.lfsr = `LFSR_PRESET;
            nx.crc = `CRC_PRESET;
            nx.state = ST_TX_DATA;
          end
        end
      end
      ST_TX_DATA, ST_TX_CRC: begin
        if (tick) begin
          raw = (st.state == ST_TX_DATA) ? st.shreg[7] : ~st.crc[15];
          // first chip is the bit, second its inverse
          nx.chip = (manch && st.half) ? ~(raw ^ (white & st.lfsr[0])) : raw ^ (white & st.lfsr[0]);
          nx.half = manch & ~st.half;
          bit_done = !manch || st.half;
        end
        if (bit_done) begin
          nx.lfsr = lfsr_step(st.lfsr);
          if (st.state == ST_TX_CRC) begin
            nx.crc = {st.crc[14:0], 1'b0};
            nx.sidx = st.sidx - 1'b1;
            if (st.sidx == 5'h00) begin
              nx.state = ST_TX_DONE;
            end
          end else begin
            nx.crc = crc_step(st.crc, raw);
            nx.shreg = {st.shreg[6:0], 1'b0};
            nx.bit_cnt = st.bit_cnt - 1'b1;
            if (st.bit_cnt == 3'h0) begin
              nx.byte_cnt = st.byte_cnt + 1'b1;
              if ({1'b0, st.byte_cnt} + 1'b1 == st.pay_len) begin
                nx.sidx = `CRC_TOP;
                nx.state = check_enable_i ? ST_TX_CRC : ST_TX_DONE;
              end else begin
                eng_pop = 1'b1;
                nx.shreg = q_out_data;
              end
            end
          end
        end
      end
      ST_TX_DONE: begin
        // flag after last chip period ends
        if (tick) begin
          nx.tx_done = 1'b1;
          nx.chip = 1'b0;
          nx.state = ST_IDLE;
        end
      end
      ST_RX_HUNT: begin
        if (tick) begin
          nx.sync_sh = {st.sync_sh[30:0], st.rx_level};
          if (nx.sync_sh == sync_pattern_i) begin
            nx.frame_match = 1'b1;
            nx.rx_msg = 1'b0;
            nx.check_pass = 1'b0;
            nx.byte_cnt = 8'h00;
            nx.bit_cnt = `BYTE_TOP;
            nx.half = 1'b0;
            nx.lfsr = `LFSR_PRESET;
            nx.crc = `CRC_PRESET;
            nx.pay_len = {1'b0, length_limit_i};
            nx.state = ST_RX_DATA;
          end
        end
      end
      ST_RX_DATA, ST_RX_CRC: begin
        if (tick) begin
          // decode takes the first chip of each pair
          nx.m_first = st.rx_level;
          nx.half = manch & ~st.half;
          bit_done = !manch || st.half;
        end
        rx_bit = ((manch ? st.m_first : st.rx_level)) ^ (white & st.lfsr[0]);
        if (bit_done) begin
          nx.lfsr = lfsr_step(st.lfsr);
          if (st.state == ST_RX_CRC) begin
            rx_crc = {st.sync_sh[14:0], rx_bit};
            nx.sync_sh = {16'h0000, rx_crc};
            nx.sidx = st.sidx - 1'b1;
            if (st.sidx == 5'h00) begin
              nx.check_pass = (rx_crc == ~st.crc);
              finish_ok = (rx_crc == ~st.crc) || keep_on_check_fail_i;
              fail_drop = !finish_ok;
            end
          end else begin
            nx.crc = crc_step(st.crc, rx_bit);
            nx.shreg = {st.shreg[6:0], rx_bit};
            nx.bit_cnt = st.bit_cnt - 1'b1;
            if (st.bit_cnt == 3'h0) begin
              byte_val = {st.shreg[6:0], rx_bit};
              nx.byte_cnt = st.byte_cnt + 1'b1;
              if (variable_length_i && st.byte_cnt == 8'h00) begin
                nx.pay_len = {1'b0, byte_val} + 1'b1;
                discard = (byte_val >= length_limit_i);
              end
              if (st.byte_cnt == {7'h00, variable_length_i} && node_filter_select_i != 2'h0) begin
                if (!(byte_val == own_node_id_i ||
                      (node_filter_select_i == `FILT_GROUP && byte_val == group_node_id_i)) ||
                    (node_filter_select_i != `FILT_OWN && node_filter_select_i != `FILT_GROUP)) begin
                  discard = 1'b1;
                end
              end
              // address byte stays in the queue
              eng_push = !discard;
              if (!discard && {1'b0, st.byte_cnt} + 1'b1 == nx.pay_len) begin
                nx.sidx = `CRC_TOP;
                if (check_enable_i) begin
                  nx.state = ST_RX_CRC;
                end else begin
                  finish_ok = 1'b1;
                end
              end
            end
          end
        end
      end
      ST_RX_END: begin
        if (!mode_rx_i) begin
          nx.state = ST_IDLE;
        end
      end
      default: begin
        nx.state = ST_IDLE;
      end
    endcase
    // keep or clear; checksum bytes never queued
    if (finish_ok) begin
      if (cipher_enable_i) begin
        nx.blocks_left = blocks_of(st.pay_len);
        nx.cipher_cnt = 16'(CIPHER_CYCLES - 1);
        nx.state = ST_RX_CIPHER;
      end else begin
        nx.rx_msg = 1'b1;
        nx.state = ST_RX_END;
      end
    end
    if (fail_drop) begin
      q_clear = 1'b1;
      nx.state = ST_RX_END;
    end
    // rejection drops the shared match flag
    if (discard) begin
      q_clear = 1'b1;
      nx.frame_match = 1'b0;
      nx.sync_sh = 32'h0000_0000;
      nx.state = ST_RX_HUNT;
    end
    if ((is_tx(st.state) && !mode_tx_i) || (!is_tx(st.state) && st.state != ST_IDLE && !mode_rx_i)) begin
      nx.state = ST_IDLE;
      nx.chip = 1'b0;
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      st <= '0;
    end else if (ce_i) begin
      st <= nx;
    end
  end

  assign host_wr_ready_o = q_in_ready;
  assign host_rd_valid_o = q_out_valid;
  assign host_rd_data_o = q_out_data;
  assign tx_chip_o = st.chip;
  assign rx_message_available_o = st.rx_msg;
  assign check_pass_flag_o = st.check_pass;
  assign tx_done_flag_o = st.tx_done;
  assign queue_level_flag_o = st.level;
  assign queue_full_flag_o = st.full;
  assign queue_nonempty_flag_o = st.nonempty;
  assign frame_match_flag_o = st.frame_match;

  ////////////////////////////////////////////////////////////////////////
  // checks

  tx_done_end_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    $rose(tx_done_flag_o) |-> $past(st.state) == ST_TX_DONE && $past(tick))
    else $error("tx done raised before final chip ended");

  tx_cipher_delay_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (st.state == ST_TX_PRE && $past(st.state) != ST_TX_PRE && $past(cipher_enable_i))
      |-> $past(st.state) == ST_TX_CIPHER)
    else $error("transmit started without encryption delay");

  rx_cipher_wait_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    ($rose(rx_message_available_o) && $past(cipher_enable_i)) |-> $past(st.state) == ST_RX_CIPHER)
    else $error("receive complete without decryption delay");

  check_first_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (st.state == ST_RX_CIPHER) |-> !rx_message_available_o)
    else $error("receive complete during decryption");

  sync_gate_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    $rose(rx_message_available_o) |-> frame_match_flag_o)
    else $error("receive event without sync match");

  sync_match_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ce_i && st.state == ST_RX_HUNT && nx.state == ST_RX_DATA) |=> frame_match_flag_o)
    else $error("sync match did not set match flag");

  filter_reject_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ce_i && discard && mode_rx_i) |=> st.state == ST_RX_HUNT && !frame_match_flag_o && q_count == 5'h00)
    else $error("rejected packet not dropped");

  check_drop_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ce_i && fail_drop && mode_rx_i) |=> q_count == 5'h00 && !rx_message_available_o)
    else $error("failed checksum packet not cleared");

  manch_pair_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ce_i && tick && st.half && manch && st.state == ST_TX_DATA && mode_tx_i)
      |=> tx_chip_o != $past(tx_chip_o))
    else $error("Manchester chip pair not inverted");

  lfsr_preset_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (st.state == ST_TX_DATA && $past(st.state) == ST_TX_SYNC) |-> st.lfsr == `LFSR_PRESET && st.crc == `CRC_PRESET)
    else $error("per-packet presets missing");

endmodule : packet_handler

`default_nettype wire

// ==== verilog/packet_handler_regs.svh ====
/*
  Constants for the packet handler core: coding selects, filter selects,
  checksum and whitening presets, queue shape and timing figures.
  Assumes inclusion by bare name from the packet handler core module.
*/
`ifndef PACKET_HANDLER_REGS_SVH
`define PACKET_HANDLER_REGS_SVH

// balance coding select
`define CODING_MANCH 2'h1
`define CODING_WHITE 2'h2

// node filter select
`define FILT_OWN 2'h1
`define FILT_GROUP 2'h2

// checksum and whitening
`define CRC_POLY 16'h1021
`define CRC_PRESET 16'h1D0F
`define LFSR_PRESET 9'h1FF
`define LFSR_TAP 5

// frame layout
`define SYNC_TOP 5'h1F
`define CRC_TOP 5'h0F
`define BYTE_TOP 3'h7

// queue shape
`define QUEUE_WIDTH 8
`define QUEUE_DEPTH 16

// cipher timing
`define CIPHER_BLOCK_NS 7000
`define MCLK_PERIOD_NS 5
`define CIPHER_BLOCK_ROUND 10'h00F
`define CIPHER_MAX_BLOCKS 3'h4

`endif

// ==== verilog/packet_handler_pkg.sv ====
/*
  Types of the packet handler core: engine states and the packed state word.
  Assumes nothing of its surroundings.
*/
package packet_handler_pkg;

  typedef enum logic [3:0] {
    ST_IDLE      = 4'b0000,
    ST_TX_CIPHER = 4'b0001,
    ST_TX_PRE    = 4'b0010,
    ST_TX_SYNC   = 4'b0011,
    ST_TX_DATA   = 4'b0100,
    ST_TX_CRC    = 4'b0101,
    ST_TX_DONE   = 4'b0110,
    ST_RX_HUNT   = 4'b0111,
    ST_RX_DATA   = 4'b1000,
    ST_RX_CRC    = 4'b1001,
    ST_RX_CIPHER = 4'b1010,
    ST_RX_END    = 4'b1011
  } state_t;

  typedef struct packed {
    state_t state;
    logic [2:0] rx_pipe;
    logic rx_level;
    logic [15:0] tick_cnt;
    logic half;
    logic m_first;
    logic [2:0] bit_cnt;
    logic [7:0] shreg;
    logic [15:0] crc;
    logic [8:0] lfsr;
    logic [31:0] sync_sh;
    logic [4:0] sidx;
    logic [7:0] pre_cnt;
    logic [7:0] byte_cnt;
    logic [8:0] pay_len;
    logic [15:0] cipher_cnt;
    logic [2:0] blocks_left;
    logic chip;
    logic tx_done;
    logic rx_msg;
    logic check_pass;
    logic frame_match;
    logic level;
    logic full;
    logic nonempty;
  } core_state_t;

endpackage : packet_handler_pkg

// ==== verilog/byte_queue.sv ====
/*
  Byte queue between host and packet engine, with valid/ready on both sides.
  Assumes one clock, a synchronous clear and a clock enable from the core.
*/
`timescale 1ns/1ps
`default_nettype none

module byte_queue #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic clear_i,
  // filling side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // draining side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i,
  // fill level
  output logic [$clog2(DEPTH):0] count_o
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic in_ready;
    logic out_valid;
  } queue_state_t;

  queue_state_t st;
  queue_state_t next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : bump

  assign push = ce_i && !clear_i && in_valid_i && st.in_ready;
  assign pop = ce_i && !clear_i && out_ready_i && st.out_valid;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.wr_ptr = bump(st.wr_ptr);
    end
    if (pop) begin
      next_st.rd_ptr = bump(st.rd_ptr);
    end
    next_st.count = st.count + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
    // a clear drops everything, including a push of the same cycle
    if (clear_i) begin
      next_st = '0;
    end
    // flags are flops, so the ports are glitch free
    next_st.in_ready = (next_st.count != (AW + 1)'(DEPTH));
    next_st.out_valid = (next_st.count != '0);
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      st <= '{default: '0, in_ready: 1'b1};
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem[st.wr_ptr] <= in_data_i;
    end
  end

  assign in_ready_o = st.in_ready;
  assign out_valid_o = st.out_valid;
  assign out_data_o = mem[st.rd_ptr];
  assign count_o = st.count;

endmodule : byte_queue

`default_nettype wire

// ==== testbench/modem_echo.sv ====
/*
  modem stand-in: records tx chips, replays them on the rx line.
  assumes it records every clock, so replay keeps each chip's length.
*/
`timescale 1ns/1ps
`default_nettype none
module modem_echo (
  // clock and control
  input wire logic mclk_i,
  input wire logic rec_i,
  input wire logic play_i,
  // chips
  input wire logic tx_chip_i,
  output logic rx_chip_o
);
  logic chips[$];
  logic idle = 1'b0;
  initial rx_chip_o = 1'b0;
  always @(posedge mclk_i) begin
    idle <= ~idle;
    if (rec_i) begin
      chips.push_back(tx_chip_i);
    end
    // silent line toggles, never holds a stale level
    if (play_i && chips.size() > 0) begin
      rx_chip_o <= #1 chips.pop_front();
    end else begin
      rx_chip_o <= #1 idle;
    end
  end
endmodule : modem_echo
`default_nettype wire

// ==== testbench/radio_packet_handler_filters_test.sv ====
/*
  loopback bench: tx packet recorded by the modem stand-in, replayed to rx.
  assumes chip rate of two clocks (rx filter drops one-clock chips) and
  six-byte frames, fixed and variable length.
*/
`timescale 1ns/1ps
`default_nettype none
module radio_packet_handler_filters_test;
  // six-byte frames fit cipher and queue
  localparam int NB = 6, QD = 16;
  logic mclk_i = 0, reset_i = 1, mode_tx = 0, mode_rx = 0, cipher = 0, check = 1, vlen = 0;
  logic wr_valid = 0, rd_ready = 0, rec = 0, play = 0, chip_rx, chip_tx;
  logic avail, pass, done, lvl, full, nonempty, match, wr_ready, rd_valid;
  logic [7:0] own_id = 0, grp_id = 0, wr_data = 0, rd_data;
  logic [1:0] filt = 0, coding = 0;
  logic [31:0] sync = 32'h8181_8181;
  logic [4:0] thr = 0;
  int fails = 0, cmp_count = 0;
  initial forever #2.5 mclk_i = ~mclk_i;
  packet_handler #(.CIPHER_BLOCK_NS(50)) packet_handler_i (.mclk_i(mclk_i), .reset_i(reset_i), .ce_i(1'b1),
    .mode_tx_i(mode_tx), .mode_rx_i(mode_rx), .chip_rate_setting_i(16'h0002), .preamble_len_i(8'h02),
    .sync_pattern_i(sync), .variable_length_i(vlen), .length_limit_i(8'(NB)), .node_filter_select_i(filt),
    .own_node_id_i(own_id), .group_node_id_i(grp_id), .check_enable_i(check), .keep_on_check_fail_i(1'b0),
    .balance_coding_select_i(coding), .cipher_enable_i(cipher), .queue_threshold_i(thr),
    .host_wr_valid_i(wr_valid), .host_wr_data_i(wr_data), .host_wr_ready_o(wr_ready),
    .host_rd_valid_o(rd_valid), .host_rd_data_o(rd_data), .host_rd_ready_i(rd_ready),
    .rx_chip_i(chip_rx), .tx_chip_o(chip_tx), .rx_message_available_o(avail), .check_pass_flag_o(pass),
    .tx_done_flag_o(done), .queue_level_flag_o(lvl), .queue_full_flag_o(full),
    .queue_nonempty_flag_o(nonempty), .frame_match_flag_o(match));
  modem_echo modem_echo_i (.mclk_i(mclk_i), .rec_i(rec), .play_i(play), .tx_chip_i(chip_tx), .rx_chip_o(chip_rx));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : tick
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic await(ref logic sig, input int lim);
    for (int i = 0; i < lim && sig !== 1'b1; i++) begin
      tick(1);
    end
  endtask : await
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////////////////////
  // full queue corner: one write refused, then drained in order
  task automatic fill_drain();
    logic [7:0] d[QD + 1];
    for (int i = 0; i <= QD; i++) begin
      d[i] = 8'($urandom);
      wr_valid = 1'b1;
      wr_data = d[i];
      tick(1);
    end
    wr_valid = 1'b0;
    tick(2);
    chk("full", 8'h01, 8'(full));
    chk("wr_ready", 8'h00, 8'(wr_ready));
    rd_ready = 1'b1;
    for (int i = 0; i < QD; i++) begin
      chk("drain", d[i], rd_data);
      tick(1);
    end
    rd_ready = 1'b0;
    tick(2);
    chk("nonempty", 8'h00, 8'(nonempty));
    chk("wr_ready", 8'h01, 8'(wr_ready));
  endtask : fill_drain
  // one frame out and back; ok says whether rx should accept it (filters, length, sync)
  task automatic run(input logic [1:0] c, input logic [1:0] f, input logic ok, input logic bad_sync);
    logic [7:0] pay[NB];
    coding = c;
    filt = f;
    thr = 5'($urandom_range(8));
    for (int i = 0; i < NB; i++) begin
      pay[i] = (vlen && i == 0) ? (ok ? 8'(NB - 1) : 8'(NB)) : 8'($urandom);
      wr_valid = 1'b1;
      wr_data = pay[i];
      tick(1);
    end
    wr_valid = 1'b0;
    own_id = (ok && f != 2'h2) ? pay[int'(vlen)] : ~pay[int'(vlen)];
    grp_id = (ok || f == 2'h1) ? pay[int'(vlen)] : ~pay[int'(vlen)];
    tick(2);
    chk("level", 8'(NB > thr), 8'(lvl));
    rec = 1'b1;
    mode_tx = 1'b1;
    await(done, 3000);
    chk("tx_done", 8'h01, 8'(done));
    mode_tx = 1'b0;
    rec = 1'b0;
    sync = bad_sync ? sync ^ 32'h0000_0001 : sync;
    mode_rx = 1'b1;
    tick(1);
    play = 1'b1;
    await(avail, 1500);
    chk("rx_avail", 8'(ok), 8'(avail));
    chk("match", 8'(ok), 8'(match));
    if (ok) begin
      chk("check_pass", 8'(check), 8'(pass));
      rd_ready = 1'b1;
      for (int i = 0; i < NB; i++) begin
        chk("rd_valid", 8'h01, 8'(rd_valid));
        chk("rx_byte", pay[i], rd_data);
        tick(1);
      end
      rd_ready = 1'b0;
    end
    tick(30);
    chk("nonempty", 8'h00, 8'(nonempty));
    play = 1'b0;
    mode_rx = 1'b0;
    tick(2);
  endtask : run
  initial begin
    void'($urandom(84));
    sync = $urandom | 32'h8080_8080;
    tick(8);
    reset_i = 1'b0;
    fill_drain();
    for (int c = 0; c < 3; c++) begin
      run(2'(c), 2'h0, 1'b1, 1'b0);
    end
    run(2'h1, 2'h1, 1'b1, 1'b0);
    run(2'h2, 2'h1, 1'b0, 1'b0);
    run(2'h0, 2'h2, 1'b1, 1'b0);
    run(2'h2, 2'h2, 1'b0, 1'b0);
    run(2'h0, 2'h0, 1'b0, 1'b1);
    vlen = 1'b1;
    run(2'h2, 2'h1, 1'b1, 1'b0);
    run(2'h0, 2'h0, 1'b0, 1'b0);
    vlen = 1'b0;
    cipher = 1'b1;
    run(2'h1, 2'h1, 1'b1, 1'b0);
    cipher = 1'b0;
    check = 1'b0;
    run(2'h0, 2'h0, 1'b1, 1'b0);
    conclude();
  end
  initial begin
    #300_000;
    fails++;
    conclude();
  end
endmodule : radio_packet_handler_filters_test
`default_nettype wire
